// ==== rtl/rh_status_pkg.sv ====
// shared constants for the root hub global status register
package rh_status_pkg;
	localparam logic [7:0] ROOT_HUB_GLOBAL_STATUS_OFS = 8'h50;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_PORTS = 2;
	localparam int BIT_CLR_GLOBAL_POWER = 0;
	localparam int BIT_OC_INDICATOR = 1;
	localparam int BIT_WAKE_ENABLE = 15;
	localparam int BIT_SET_GLOBAL_POWER = 16;
	localparam int BIT_OC_CHANGE = 17;
	localparam int BIT_CLR_WAKE = 31;
	localparam logic RESET_WAKE = 1'b0;
	localparam logic RESET_OC_CHANGE = 1'b0;
	localparam logic RESET_OC_LAST = 1'b0;
endpackage : rh_status_pkg

// ==== rtl/rh_edge_flag.sv ====
// sticky change flag with edge detect on a level input
`timescale 1ns/1ps
module rh_edge_flag (
	input wire logic clk,
	input wire logic rst,
	input wire logic level_in,
	input wire logic clear_in,
	output logic flag_out
);
	logic last_reg;
	logic last_next;
	logic flag_reg;
	logic flag_next;

	always_comb begin
		last_next = level_in;
		flag_next = flag_reg;
		if (clear_in) begin
			flag_next = 1'b0;
		end
		// set wins over a simultaneous clear so no edge is lost
		if (level_in != last_reg) begin
			flag_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			last_reg <= rh_status_pkg::RESET_OC_LAST;
			flag_reg <= rh_status_pkg::RESET_OC_CHANGE;
		end else begin
			last_reg <= last_next;
			flag_reg <= flag_next;
		end
	end

	assign flag_out = flag_reg;
endmodule : rh_edge_flag

// ==== rtl/root_hub_status_power_control.sv ====
// root hub global status, power command and remote wake register
//
// Functional notes
// - register sits at 0x50; low half is status, high half change flags
// - writing one to bit 31 clears remote wake enable; zero ignored
// - overcurrent change bit 17 sets when the overcurrent indicator changes
// - writing one to bit 17 clears overcurrent change; zero ignored
// - bit 16 always reads zero
// - global mode: writing one to bit 16 powers all ports
// - per-port mode: bit 16 write powers only unmasked ports
// - wake enable set: connect change resumes a suspended bus, flags resume
// - writing one to bit 15 sets remote wake enable; zero ignored
// - bit 1 reports global overcurrent, one meaning overcurrent present
// - per-port overcurrent protection makes bit 1 read zero
// - bit 0 always reads zero
// - global mode: writing one to bit 0 unpowers all ports
// - per-port mode: bit 0 write unpowers only unmasked ports
// - mask bit n controls port n; in per-port mode a set mask restricts to per-port commands, in global mode the mask is ignored
`timescale 1ns/1ps
module root_hub_status_power_control #(
	parameter int NUM_PORTS = rh_status_pkg::NUM_PORTS
) (
	input wire logic REF_CLK_IN,
	input wire logic RST_IN,
	input wire logic [rh_status_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic WR_EN_IN,
	input wire logic RD_EN_IN,
	input wire logic [rh_status_pkg::DATA_W-1:0] WDATA_IN,
	output logic [rh_status_pkg::DATA_W-1:0] RDATA_OUT,
	input wire logic PER_PORT_SWITCH_IN,
	input wire logic PER_PORT_OC_IN,
	input wire logic OVERCURRENT_IN,
	input wire logic [NUM_PORTS:1] PORT_POWER_MASK_IN,
	input wire logic [NUM_PORTS:1] PORT_CONNECT_CHANGE_IN,
	input wire logic BUS_SUSPENDED_STATE_IN,
	output logic [NUM_PORTS:1] PORT_POWER_SET_OUT,
	output logic [NUM_PORTS:1] PORT_POWER_CLR_OUT,
	output logic BUS_RESUME_REQ_OUT,
	output logic RESUME_DETECTED_OUT,
	output logic REMOTE_WAKE_ENABLE_OUT
);
	logic hit;
	logic wr_hit;
	logic wake_reg;
	logic wake_next;
	logic oc_ind;
	logic oc_change;
	logic [NUM_PORTS:1] sel;
	logic [NUM_PORTS:1] pset_reg;
	logic [NUM_PORTS:1] pset_next;
	logic [NUM_PORTS:1] pclr_reg;
	logic [NUM_PORTS:1] pclr_next;
	logic resume_reg;
	logic resume_next;
	logic [rh_status_pkg::DATA_W-1:0] rdata_reg;
	logic [rh_status_pkg::DATA_W-1:0] rdata_next;

	function automatic logic wr_one(input logic [rh_status_pkg::DATA_W-1:0] d, input int b);
		wr_one = d[b];
	endfunction : wr_one

	assign hit = (ADDR_IN == rh_status_pkg::ROOT_HUB_GLOBAL_STATUS_OFS);
	assign wr_hit = WR_EN_IN && hit;
	// per-port indicator masks the global one
	assign oc_ind = OVERCURRENT_IN && !PER_PORT_OC_IN;

	rh_edge_flag u_oc_flag (
		.clk(REF_CLK_IN),
		.rst(RST_IN),
		.level_in(oc_ind),
		.clear_in(wr_hit && wr_one(WDATA_IN, rh_status_pkg::BIT_OC_CHANGE)),
		.flag_out(oc_change)
	);

	// in global mode every port follows; in per-port mode masked ports ignore global commands
	assign sel = PER_PORT_SWITCH_IN ? ~PORT_POWER_MASK_IN : '1;

	always_comb begin
		wake_next = wake_reg;
		if (wr_hit && wr_one(WDATA_IN, rh_status_pkg::BIT_WAKE_ENABLE)) begin
			wake_next = 1'b1;
		end
		// clear given after set when both bits written: software asked to disable
		if (wr_hit && wr_one(WDATA_IN, rh_status_pkg::BIT_CLR_WAKE)) begin
			wake_next = 1'b0;
		end
		pset_next = '0;
		pclr_next = '0;
		if (wr_hit && wr_one(WDATA_IN, rh_status_pkg::BIT_SET_GLOBAL_POWER)) begin
			pset_next = sel;
		end
		if (wr_hit && wr_one(WDATA_IN, rh_status_pkg::BIT_CLR_GLOBAL_POWER)) begin
			pclr_next = sel;
		end
		resume_next = wake_reg && BUS_SUSPENDED_STATE_IN && (|PORT_CONNECT_CHANGE_IN);
		rdata_next = rdata_reg;
		if (RD_EN_IN) begin
			rdata_next = '0;
			if (hit) begin
				rdata_next[rh_status_pkg::BIT_OC_INDICATOR] = oc_ind;
				rdata_next[rh_status_pkg::BIT_WAKE_ENABLE] = wake_reg;
				rdata_next[rh_status_pkg::BIT_OC_CHANGE] = oc_change;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			wake_reg <= rh_status_pkg::RESET_WAKE;
			pset_reg <= '0;
			pclr_reg <= '0;
			resume_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			wake_reg <= wake_next;
			pset_reg <= pset_next;
			pclr_reg <= pclr_next;
			resume_reg <= resume_next;
			rdata_reg <= rdata_next;
		end
	end

	assign PORT_POWER_SET_OUT = pset_reg;
	assign PORT_POWER_CLR_OUT = pclr_reg;
	assign BUS_RESUME_REQ_OUT = resume_reg;
	assign RESUME_DETECTED_OUT = resume_reg;
	assign REMOTE_WAKE_ENABLE_OUT = wake_reg;
	assign RDATA_OUT = rdata_reg;

	a_wake_set: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		wr_hit && WDATA_IN[15] && !WDATA_IN[31] |=> REMOTE_WAKE_ENABLE_OUT)
		else $error("wake enable not set");
	a_wake_clear: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		wr_hit && WDATA_IN[31] |=> !REMOTE_WAKE_ENABLE_OUT)
		else $error("wake enable not cleared");
	a_wake_hold: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		!wr_hit |=> $stable(REMOTE_WAKE_ENABLE_OUT))
		else $error("wake enable changed without write");
	a_oc_edge: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		$changed(oc_ind) |=> oc_change)
		else $error("change flag missed an edge");
	a_oc_clear: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		oc_change && wr_hit && WDATA_IN[17] && $stable(oc_ind) |=> !oc_change)
		else $error("change flag not cleared");
	a_oc_sticky: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		oc_change && !(wr_hit && WDATA_IN[17]) |=> oc_change)
		else $error("change flag dropped");
	a_power_set: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		wr_hit && WDATA_IN[16] |=> PORT_POWER_SET_OUT ==
		($past(PER_PORT_SWITCH_IN) ? ~$past(PORT_POWER_MASK_IN) : {NUM_PORTS{1'b1}}))
		else $error("power set wrong ports");
	a_power_clr_sel: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		wr_hit && WDATA_IN[0] |=> PORT_POWER_CLR_OUT ==
		($past(PER_PORT_SWITCH_IN) ? ~$past(PORT_POWER_MASK_IN) : {NUM_PORTS{1'b1}}))
		else $error("power clear wrong ports");
	a_power_clr: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		!(wr_hit && WDATA_IN[0]) |=> PORT_POWER_CLR_OUT == '0)
		else $error("power clear without command");
	a_resume: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		REMOTE_WAKE_ENABLE_OUT && BUS_SUSPENDED_STATE_IN && (|PORT_CONNECT_CHANGE_IN)
		|=> BUS_RESUME_REQ_OUT && RESUME_DETECTED_OUT)
		else $error("resume not raised");
	// a resume without wake enable would wake the bus against software's wish
	a_resume_quiet: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		!(REMOTE_WAKE_ENABLE_OUT && BUS_SUSPENDED_STATE_IN && (|PORT_CONNECT_CHANGE_IN))
		|=> !BUS_RESUME_REQ_OUT && !RESUME_DETECTED_OUT)
		else $error("resume without cause");
	a_read_map: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		RD_EN_IN && hit |=> RDATA_OUT[15] == $past(wake_reg) &&
		RDATA_OUT[17] == $past(oc_change) && RDATA_OUT[1] == $past(oc_ind))
		else $error("read bit map wrong");
	a_read_reserved: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		RD_EN_IN |=> RDATA_OUT[30:18] == '0 && RDATA_OUT[14:2] == '0 && !RDATA_OUT[31])
		else $error("reserved bits not zero");
	a_read_zero: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		RD_EN_IN |=> RDATA_OUT[0] == 1'b0 && RDATA_OUT[16] == 1'b0)
		else $error("constant bits not zero");
	a_oc_perport: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
		RD_EN_IN && PER_PORT_OC_IN |=> RDATA_OUT[1] == 1'b0)
		else $error("indicator not masked");
endmodule : root_hub_status_power_control

// ==== sim/tb_root_hub_status_power_control.sv ====
// self-checking bench for the root hub global status register
`timescale 1ns/1ps
module tb_root_hub_status_power_control;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pps = 1'b0, poc = 1'b0, oc = 1'b0, susp = 1'b0;
	logic [7:0] addr = 8'h50;
	logic [31:0] wd = 32'h0, rdata, v;
	logic [2:1] mask = 2'b00, cc = 2'b00, pset, pclr;
	logic rreq, rdet, wake;
	int n_mismatch = 0, checks_done = 0;
	root_hub_status_power_control DUT (.REF_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
		.WR_EN_IN(wr), .RD_EN_IN(rd), .WDATA_IN(wd), .RDATA_OUT(rdata),
		.PER_PORT_SWITCH_IN(pps), .PER_PORT_OC_IN(poc), .OVERCURRENT_IN(oc),
		.PORT_POWER_MASK_IN(mask), .PORT_CONNECT_CHANGE_IN(cc), .BUS_SUSPENDED_STATE_IN(susp),
		.PORT_POWER_SET_OUT(pset), .PORT_POWER_CLR_OUT(pclr), .BUS_RESUME_REQ_OUT(rreq),
		.RESUME_DETECTED_OUT(rdet), .REMOTE_WAKE_ENABLE_OUT(wake));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// strobes are held across exactly one taken edge; reserved bits always written zero
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) #1 wr = 1'b1; addr = a; wd = d;
		@(posedge clk) #1 wr = 1'b0; wd = 32'h0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk) #1 rd = 1'b1; addr = a;
		@(posedge clk) #1 rd = 1'b0;
		d = rdata;
	endtask : rd_reg
	task automatic t_wake;
		rd_reg(8'h50, v); chk(v, 32'h0);
		wr_reg(8'h54, 32'h0000_8000); rd_reg(8'h50, v); chk(v, 32'h0);
		wr_reg(8'h50, 32'h0000_8000); rd_reg(8'h50, v); chk(v, 32'h0000_8000);
		chk(wake, 1'b1);
		wr_reg(8'h50, 32'h0); chk(wake, 1'b1);
		wr_reg(8'h50, 32'h8000_0000); rd_reg(8'h50, v); chk(v, 32'h0);
		rd_reg(8'h40, v); chk(v, 32'h0);
	endtask : t_wake
	task automatic t_power;
		wr_reg(8'h50, 32'h0001_0000); chk({pset, pclr}, 4'b1100);
		wr_reg(8'h50, 32'h0000_0001); chk({pset, pclr}, 4'b0011);
		rd_reg(8'h50, v); chk(v, 32'h0);
		pps = 1'b1; mask = 2'b10;
		wr_reg(8'h50, 32'h0001_0001); chk({pset, pclr}, 4'b0101);
		@(posedge clk) #1 chk({pset, pclr}, 4'b0000);
		mask = 2'b01;
		wr_reg(8'h50, 32'h0000_0001); chk(pclr, 2'b10);
		pps = 1'b0; mask = 2'b00;
	endtask : t_power
	task automatic t_oc;
		oc = 1'b1; repeat (3) @(posedge clk);
		rd_reg(8'h50, v); chk(v, 32'h0002_0002);
		wr_reg(8'h50, 32'h0); rd_reg(8'h50, v); chk(v, 32'h0002_0002);
		wr_reg(8'h50, 32'h0002_0000); rd_reg(8'h50, v); chk(v, 32'h0000_0002);
		oc = 1'b0; repeat (3) @(posedge clk);
		rd_reg(8'h50, v); chk(v, 32'h0002_0000);
		wr_reg(8'h50, 32'h0002_0000);
		poc = 1'b1; oc = 1'b1; repeat (3) @(posedge clk);
		rd_reg(8'h50, v); chk(v[1], 1'b0);
		poc = 1'b0; oc = 1'b0; repeat (3) @(posedge clk);
		wr_reg(8'h50, 32'h0002_0000);
	endtask : t_oc
	task automatic t_resume;
		wr_reg(8'h50, 32'h0000_8000);
		susp = 1'b1; cc = 2'b10;
		@(posedge clk) #1 chk({rreq, rdet}, 2'b11);
		cc = 2'b00;
		@(posedge clk) #1 chk({rreq, rdet}, 2'b00);
		wr_reg(8'h50, 32'h8000_8000); chk(wake, 1'b0);
		cc = 2'b01;
		repeat (2) @(posedge clk);
		#1 chk({rreq, rdet}, 2'b00);
		cc = 2'b00; susp = 1'b0;
	endtask : t_resume
	task automatic stop_test;
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		t_wake();
		t_power();
		t_oc();
		t_resume();
		stop_test();
	end
endmodule : tb_root_hub_status_power_control
